/* File: src/uart_tx_pkg.sv */
/*
 * Constants and types shared by the transmit path of one asynchronous serial channel.
 * Assumes a single clock domain (mclk) and an active-high asynchronous reset.
 */
// Summary of operation
// - Holding buffer is sixteen-byte first-in first-out store in buffered mode, one byte in legacy mode.
// - Bit timing from clock divided by divisor.
// - Line settings set length, parity, stop bits.
// - Host-written bytes are accepted into holding buffer.
// - Oldest byte loads shifter only when idle.
// - Shifter serializes byte with framing bits added.
// - Legacy mode: interrupt when empty and enabled.
// - Legacy mode: loading a character clears interrupt.
// - Buffered mode: interrupt follows buffer control settings.
// - Baud generator ticks at sixteen times baud.
// - Divisor in two byte latches; writes reload counter.
package uart_tx_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam int DIV_W = 16;
	localparam int TICK_W = 6;

	localparam logic [CNT_W-1:0] DEPTH_BUFFERED = 5'h10;
	localparam logic [CNT_W-1:0] DEPTH_LEGACY = 5'h01;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
	localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
	localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;

	// ------------------------------------------------------------
	// Bit timing in sixteenth-of-bit ticks
	// ------------------------------------------------------------
	localparam logic [TICK_W-1:0] TICKS_BIT = 6'h10;
	localparam logic [TICK_W-1:0] TICKS_STOP_ONE = 6'h10;
	localparam logic [TICK_W-1:0] TICKS_STOP_HALF = 6'h18;
	localparam logic [TICK_W-1:0] TICKS_STOP_TWO = 6'h20;
	localparam logic [TICK_W-1:0] TICK_ONE = 6'h01;

	// ------------------------------------------------------------
	// Character length codes and framing
	// ------------------------------------------------------------
	localparam logic [1:0] LEN_FIVE = 2'h0;
	localparam logic [2:0] LAST_BIT_BASE = 3'h4;
	localparam logic [2:0] BIT_ZERO = 3'h0;
	localparam logic LINE_IDLE = 1'b1;
	localparam logic LINE_START = 1'b0;

	// Transmitter states, one-hot.
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_LOAD = 6'h02,
		ST_START = 6'h04,
		ST_DATA = 6'h08,
		ST_PARITY = 6'h10,
		ST_STOP = 6'h20
	} tx_state_e;

endpackage : uart_tx_pkg

/* File: src/fifo_mem_if.sv */
/*
 * Interface between the holding-buffer control and its storage array.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/1ps
interface fifo_mem_if;
	import uart_tx_pkg::*;

	// Write port and read port of the storage array.
	logic we;
	logic [PTR_W-1:0] waddr;
	logic [DATA_W-1:0] wdata;
	logic [PTR_W-1:0] raddr;
	logic [DATA_W-1:0] rdata;

	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);

endinterface : fifo_mem_if

/* File: src/tx_fifo_mem.sv */
/*
 * Sixteen-entry byte array backing the transmit holding buffer.
 * Assumes the controller never writes and reads a slot it has not yet filled.
 */
`timescale 1ns/1ps
module tx_fifo_mem
	import uart_tx_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Array ports
	fifo_mem_if.mem port
);

	logic [DATA_W-1:0] store [FIFO_DEPTH];

	// -----------------------------------------------------------
	// Storage
	// -----------------------------------------------------------
	// No reset on the array: contents are only read after a write.
	always_ff @(posedge mclk)
	begin
		if (port.we)
		begin
			store[port.waddr] <= port.wdata;
		end
	end

	// Registered read; the controller waits one cycle for it.
	always_ff @(posedge mclk)
	begin
		port.rdata <= store[port.raddr];
	end

endmodule : tx_fifo_mem

/* File: src/uart_transmit_path.sv */
/*
 * Transmit path of one asynchronous serial channel: holding buffer, baud
 * generator, shift register and holding-empty interrupt.
 * Assumes the host presents writes synchronous to mclk, one byte per strobe,
 * and that line settings are steady while a character is on the line.
 */
`timescale 1ns/1ps
module uart_transmit_path
	import uart_tx_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Host character writes
	input wire logic [7:0] wr_data,
	input wire logic wr_strobe,
	// Divisor latch writes
	input wire logic [7:0] div_lo_data,
	input wire logic div_lo_wr,
	input wire logic [7:0] div_hi_data,
	input wire logic div_hi_wr,
	// Line settings
	input wire logic [1:0] char_len,
	input wire logic extra_stop,
	input wire logic parity_en,
	input wire logic parity_even,
	input wire logic parity_stick,
	input wire logic break_en,
	// Buffer control
	input wire logic buffered_mode,
	input wire logic buffer_clear,
	input wire logic holding_empty_irq_enable,
	// Serial line and status
	output logic tx_serial,
	output logic holding_empty_flag,
	output logic holding_full,
	output logic tx_all_empty,
	output logic tx_irq
);

	// -----------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------
	fifo_mem_if mem_bus ();

	logic [7:0] div_lo_q;
	logic [7:0] div_hi_q;
	logic [DIV_W-1:0] baud_cnt_q;
	logic baud_tick_q;
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic [CNT_W-1:0] capacity;
	logic push;
	logic pop;
	tx_state_e state_q;
	tx_state_e state_d;
	logic [DATA_W-1:0] tx_shift_register_q;
	logic parity_q;
	logic [2:0] bit_idx_q;
	logic [2:0] last_bit;
	logic [TICK_W-1:0] tick_cnt_q;
	logic [TICK_W-1:0] stop_ticks;
	logic bit_done;
	logic line_d;

	// -----------------------------------------------------------
	// Divisor latches and baud generator
	// -----------------------------------------------------------
	// Two byte latches form the sixteen-bit divisor.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			div_lo_q <= DIV_RESET[7:0];
			div_hi_q <= DIV_RESET[15:8];
		end
		else
		begin
			if (div_lo_wr)
				div_lo_q <= div_lo_data;
			if (div_hi_wr)
				div_hi_q <= div_hi_data;
		end
	end

	// Down counter gives one tick per divisor period, i.e. sixteen per bit.
	// Reloading on a latch write avoids a long count left from the old value.
	// A divisor of zero stops the generator altogether.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			baud_cnt_q <= DIV_RESET;
			baud_tick_q <= 1'b0;
		end
		else if (div_lo_wr || div_hi_wr)
		begin
			baud_cnt_q <= {div_hi_wr ? div_hi_data : div_hi_q, div_lo_wr ? div_lo_data : div_lo_q};
			baud_tick_q <= 1'b0;
		end
		else if (baud_cnt_q <= DIV_ONE)
		begin
			baud_cnt_q <= {div_hi_q, div_lo_q};
			baud_tick_q <= (baud_cnt_q == DIV_ONE);
		end
		else
		begin
			baud_cnt_q <= baud_cnt_q - DIV_ONE;
			baud_tick_q <= 1'b0;
		end
	end

	// -----------------------------------------------------------
	// Holding buffer control
	// -----------------------------------------------------------
	// Legacy mode behaves as a one-character register.
	assign capacity = buffered_mode ? DEPTH_BUFFERED : DEPTH_LEGACY;
	// A write to a full buffer is dropped; holding_full warns the host.
	assign push = wr_strobe && (count_q < capacity) && !buffer_clear;
	assign pop = (state_q == ST_LOAD);
	assign count_d = buffer_clear ? '0 : count_q + (push ? CNT_ONE : '0) - (pop ? CNT_ONE : '0);

	assign mem_bus.we = push;
	assign mem_bus.waddr = wr_ptr_q;
	assign mem_bus.wdata = wr_data;
	assign mem_bus.raddr = rd_ptr_q;

	tx_fifo_mem u_mem (
		.mclk (mclk),
		.port (mem_bus.mem)
	);

	// Pointers and fill level of the first-in first-out store.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (buffer_clear)
				wr_ptr_q <= rd_ptr_q + (pop ? PTR_ONE : '0);
			else if (push)
				wr_ptr_q <= wr_ptr_q + PTR_ONE;
			if (pop)
				rd_ptr_q <= rd_ptr_q + PTR_ONE;
			count_q <= count_d;
		end
	end

	// -----------------------------------------------------------
	// Framing arithmetic
	// -----------------------------------------------------------
	// Index of the last data bit: five to eight bits.
	assign last_bit = LAST_BIT_BASE + {1'b0, char_len};

	// One and a half stop bits apply only to five-bit characters.
	always_comb
	begin
		if (!extra_stop)
			stop_ticks = TICKS_STOP_ONE;
		else if (char_len == LEN_FIVE)
			stop_ticks = TICKS_STOP_HALF;
		else
			stop_ticks = TICKS_STOP_TWO;
	end

	assign bit_done = baud_tick_q && (tick_cnt_q == ((state_q == ST_STOP) ? stop_ticks : TICKS_BIT) - TICK_ONE);

	// -----------------------------------------------------------
	// Transmitter sequencing
	// -----------------------------------------------------------
	// IDLE waits one cycle in LOAD so the registered read data are valid.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (count_q != '0 && !buffer_clear)
					state_d = ST_LOAD;
			end
			ST_LOAD:
				state_d = ST_START;
			ST_START:
			begin
				if (bit_done)
					state_d = ST_DATA;
			end
			ST_DATA:
			begin
				if (bit_done && bit_idx_q == last_bit)
					state_d = parity_en ? ST_PARITY : ST_STOP;
			end
			ST_PARITY:
			begin
				if (bit_done)
					state_d = ST_STOP;
			end
			ST_STOP:
			begin
				if (bit_done)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Sixteenth-of-bit counter restarts at every bit boundary.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			tick_cnt_q <= '0;
		else if (state_q == ST_LOAD || bit_done)
			tick_cnt_q <= '0;
		else if (baud_tick_q)
			tick_cnt_q <= tick_cnt_q + TICK_ONE;
	end

	// Shift register loads the oldest byte and shifts out LSB first.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			tx_shift_register_q <= '0;
			bit_idx_q <= BIT_ZERO;
			parity_q <= 1'b0;
		end
		else if (state_q == ST_LOAD)
		begin
			tx_shift_register_q <= mem_bus.rdata;
			bit_idx_q <= BIT_ZERO;
			// Unused upper bits are masked before parity is formed.
			if (parity_stick)
				parity_q <= !parity_even;
			else
				// The shift amount is widened so that eight-bit characters do not wrap to zero.
				parity_q <= parity_even ^ ~(^(mem_bus.rdata & ~(8'hFF << ({1'b0, last_bit} + 4'h1))));
		end
		else if (state_q == ST_DATA && bit_done)
		begin
			tx_shift_register_q <= tx_shift_register_q >> 1;
			bit_idx_q <= bit_idx_q + 3'h1;
		end
	end

	// -----------------------------------------------------------
	// Line and status outputs
	// -----------------------------------------------------------
	always_comb
	begin
		case (state_q)
			ST_START:
				line_d = LINE_START;
			ST_DATA:
				line_d = tx_shift_register_q[0];
			ST_PARITY:
				line_d = parity_q;
			default:
				line_d = LINE_IDLE;
		endcase
	end

	// All outputs registered; break holds the line low regardless of state.
	// The interrupt is a level taken from the next fill count, so a load
	// drops it on the same edge that stores the byte.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			tx_serial <= LINE_IDLE;
			holding_empty_flag <= 1'b1;
			holding_full <= 1'b0;
			tx_all_empty <= 1'b1;
			tx_irq <= 1'b0;
		end
		else
		begin
			tx_serial <= break_en ? LINE_START : line_d;
			holding_empty_flag <= (count_d == '0);
			holding_full <= (count_d >= capacity);
			tx_all_empty <= (count_d == '0) && (state_d == ST_IDLE);
			if (buffered_mode)
				tx_irq <= holding_empty_irq_enable && (count_d == '0);
			else
				tx_irq <= holding_empty_irq_enable && (count_d == '0);
		end
	end

endmodule : uart_transmit_path

/* File: verification/uart_transmit_path_asserts.sv */
/* Port checker for the transmit path: flags, interrupt and line timing.
   Assumes it is bound to the top module and that break stays low. */
`timescale 1ns/1ps
module uart_transmit_path_asserts
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Inputs watched
	input wire logic wr_strobe,
	input wire logic buffered_mode,
	input wire logic buffer_clear,
	input wire logic holding_empty_irq_enable,
	// Outputs watched
	input wire logic tx_serial,
	input wire logic holding_empty_flag,
	input wire logic holding_full,
	input wire logic tx_all_empty,
	input wire logic tx_irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// A write that the buffer must take, and the start bit that follows it.
	sequence s_accept;
		wr_strobe && !buffer_clear && holding_empty_flag;
	endsequence
	sequence s_start;
		##[3:6] $fell(tx_serial);
	endsequence

	property p_full_not_empty; holding_full |-> !holding_empty_flag; endproperty
	a_full_not_empty: assert property (p_full_not_empty) else $error("full and empty together");
	property p_irq_empty; tx_irq |-> holding_empty_flag; endproperty
	a_irq_empty: assert property (p_irq_empty) else $error("interrupt while data held");
	property p_irq_raise; holding_empty_irq_enable && holding_empty_flag && !wr_strobe |=> tx_irq; endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("interrupt missing while empty");
	property p_write_clears; s_accept |=> !holding_empty_flag && !tx_irq; endproperty
	a_write_clears: assert property (p_write_clears) else $error("write did not clear empty state");
	property p_legacy_one; s_accept |=> holding_full == !$past(buffered_mode); endproperty
	a_legacy_one: assert property (p_legacy_one) else $error("capacity wrong after one write");
	property p_fall_write; $fell(holding_empty_flag) |-> $past(wr_strobe); endproperty
	a_fall_write: assert property (p_fall_write) else $error("buffer filled without a write");
	property p_idle_line; tx_all_empty && $past(tx_all_empty) |-> tx_serial; endproperty
	a_idle_line: assert property (p_idle_line) else $error("line low while idle");
	property p_start_len; $fell(tx_serial) |-> !tx_serial [*8]; endproperty
	a_start_len: assert property (p_start_len) else $error("start bit too short");
	property p_load_idle; s_accept and tx_all_empty |-> s_start; endproperty
	a_load_idle: assert property (p_load_idle) else $error("idle shifter not loaded");
endmodule : uart_transmit_path_asserts

/* File: verification/host_writer.sv */
/* Host model that writes characters into the holding buffer.
   Assumes the bench calls send and that mclk runs. */
`timescale 1ns/1ps
module host_writer
(
	// Clock
	input wire logic mclk,
	// Character writes
	output logic [7:0] wr_data,
	output logic wr_strobe
);
	// The data bus is inverted when idle so stale data never looks valid.
	initial
	begin
		wr_data = 8'hA5;
		wr_strobe = 1'b0;
	end

	// One byte per strobe at the falling edge; gap cycles make a slow host.
	task automatic send(input logic [7:0] v, input int gap);
		@(negedge mclk);
		wr_data = v;
		wr_strobe = 1'b1;
		@(negedge mclk);
		wr_strobe = 1'b0;
		wr_data = ~v;
		repeat (gap) @(negedge mclk);
	endtask : send
endmodule : host_writer

/* File: verification/test_uart_transmit_path.sv */
/* Self-checking bench: host model writes, a decoder checks every character on the line.
   Assumes the checker and host model are compiled first; break stays low. */
`timescale 1ns/1ps
module test_uart_transmit_path;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] wr_data, div_lo_data, div_hi_data, e, got;
	logic wr_strobe, div_lo_wr, div_hi_wr, extra_stop, parity_en, parity_even, parity_stick;
	logic buffered_mode, holding_empty_irq_enable, pb, buffer_clear;
	logic [1:0] char_len;
	logic tx_serial, holding_empty_flag, holding_full, tx_all_empty, tx_irq;
	logic [31:0] seed = 32'h0000003A;
	logic [7:0] exp_q[$];
	int n_fail = 0;
	int total_checks = 0;
	int dv = 1;
	int i, j;
	bit busy = 1'b0;

	always #25 mclk = ~mclk;

	host_writer i_host (.mclk(mclk), .wr_data(wr_data), .wr_strobe(wr_strobe));
	uart_transmit_path i_dut (.mclk(mclk), .rst(rst), .wr_data(wr_data), .wr_strobe(wr_strobe),
		.div_lo_data(div_lo_data), .div_lo_wr(div_lo_wr), .div_hi_data(div_hi_data), .div_hi_wr(div_hi_wr),
		.char_len(char_len), .extra_stop(extra_stop), .parity_en(parity_en), .parity_even(parity_even),
		.parity_stick(parity_stick), .break_en(1'b0), .buffered_mode(buffered_mode), .buffer_clear(buffer_clear),
		.holding_empty_irq_enable(holding_empty_irq_enable), .tx_serial(tx_serial),
		.holding_empty_flag(holding_empty_flag), .holding_full(holding_full), .tx_all_empty(tx_all_empty),
		.tx_irq(tx_irq));

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] s);
		total_checks++;
		if (s !== x)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, s);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	// Low latch then high latch, each write reloading the baud counter.
	task automatic setdiv(input logic [15:0] d);
		@(negedge mclk);
		div_lo_data = d[7:0];
		div_lo_wr = 1'b1;
		@(negedge mclk);
		div_lo_wr = 1'b0;
		div_hi_data = d[15:8];
		div_hi_wr = 1'b1;
		@(negedge mclk);
		div_hi_wr = 1'b0;
		dv = d;
	endtask : setdiv

	task automatic put(input logic [7:0] v, input bit acc, input int gap);
		if (acc)
			exp_q.push_back(v);
		i_host.send(v, gap);
	endtask : put

	// Bounded wait until every queued byte has left the line.
	task automatic drain();
		int n;
		for (n = 0; n < 20000 && !(tx_all_empty === 1'b1 && !busy && exp_q.size() == 0); n++)
			@(negedge mclk);
		chk("drain timeout", 8'h00, {7'h00, n == 20000});
		if (n == 20000)
			stop_test();
		repeat (4) @(negedge mclk);
	endtask : drain

	// Decoder samples near mid-bit; an unexpected frame pops an unknown and fails.
	initial
	forever
	begin
		@(negedge mclk iff (tx_serial === 1'b0 && !rst));
		busy = 1'b1;
		e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
		e = e & (8'hFF >> (3 - char_len));
		repeat (8 * dv - 1) @(negedge mclk);
		chk("start", 8'h00, {7'h00, tx_serial});
		got = 8'h00;
		for (j = 0; j < char_len + 5; j++)
		begin
			repeat (16 * dv) @(negedge mclk);
			got[j] = tx_serial;
		end
		chk("data", e, got);
		pb = parity_stick ? !parity_even : (parity_even ? ^e : ~^e);
		if (parity_en)
		begin
			repeat (16 * dv) @(negedge mclk);
			chk("parity", {7'h00, pb}, {7'h00, tx_serial});
		end
		repeat (16 * dv) @(negedge mclk);
		chk("stop", 8'h01, {7'h00, tx_serial});
		busy = 1'b0;
	end

	initial
	begin
		{div_lo_wr, div_hi_wr, extra_stop, parity_en, parity_even, parity_stick, holding_empty_irq_enable,
			buffer_clear} = 8'h00;
		{div_lo_data, div_hi_data, char_len, buffered_mode} = 19'h00007;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		chk("reset", 8'h1A, {3'h0, tx_serial, holding_empty_flag, holding_full, tx_all_empty, tx_irq});
		$display("test reset done");
		// Every length, parity mode and stop count, two bytes back to back.
		for (i = 0; i < 8; i++)
		begin
			setdiv(16'(i % 2 + 1));
			{extra_stop, parity_stick, parity_even, parity_en} = {i[2], i[2] & i[0], i[1], i[0]};
			char_len = i[1:0];
			put(rnd(), 1'b1, 0);
			put(rnd(), 1'b1, 0);
			drain();
		end
		$display("test framing done");
		buffered_mode = 1'b0;
		holding_empty_irq_enable = 1'b1;
		repeat (2) @(negedge mclk);
		chk("irq idle", 8'h01, {7'h00, tx_irq});
		put(8'h3C, 1'b1, 0);
		chk("legacy flags", 8'h02, {6'h00, holding_full, tx_irq});
		put(8'hC3, 1'b0, 0);
		drain();
		chk("irq drained", 8'h01, {7'h00, tx_irq});
		holding_empty_irq_enable = 1'b0;
		repeat (2) @(negedge mclk);
		chk("irq masked", 8'h00, {7'h00, tx_irq});
		$display("test legacy done");
		// Fill while the shifter is busy: sixteen taken, the seventeenth dropped.
		buffered_mode = 1'b1;
		holding_empty_irq_enable = 1'b1;
		setdiv(16'h0002);
		put(rnd(), 1'b1, 0);
		repeat (6) @(negedge mclk);
		for (i = 0; i < 17; i++)
			put(rnd(), i < 16, 0);
		chk("full", 8'h02, {6'h00, holding_full, tx_irq});
		drain();
		chk("irq empty", 8'h01, {7'h00, tx_irq});
		$display("test buffered done");
		// A clear empties the buffer, but the character already on the line must finish.
		put(rnd(), 1'b1, 0);
		put(rnd(), 1'b0, 0);
		put(rnd(), 1'b0, 0);
		buffer_clear = 1'b1;
		@(negedge mclk);
		buffer_clear = 1'b0;
		@(negedge mclk);
		chk("clear empty", 8'h01, {7'h00, holding_empty_flag});
		drain();
		$display("test clear done");
		stop_test();
	end
endmodule : test_uart_transmit_path

bind uart_transmit_path uart_transmit_path_asserts i_chk (.mclk(mclk), .rst(rst), .wr_strobe(wr_strobe),
	.buffered_mode(buffered_mode), .buffer_clear(buffer_clear), .holding_empty_irq_enable(holding_empty_irq_enable),
	.tx_serial(tx_serial), .holding_empty_flag(holding_empty_flag), .holding_full(holding_full),
	.tx_all_empty(tx_all_empty), .tx_irq(tx_irq));
